// *** hw/dacp_map.vh ***
`ifndef DACP_MAP_VH
`define DACP_MAP_VH
`define DACP_IN_BUS_W 14
`define DACP_IN_SAMPLE_W 12
`define DACP_IN_MSB 13
`define DACP_IN_LSB 2
`define DACP_OUT_W 16
`define DACP_OUT_MID 16'h8000
`define DACP_IN_MID 12'h800
`define DACP_SPI_W 16
`define DACP_SPI_CNT_W 5
`define DACP_SPI_DIV 4'h3
`define DACP_AUX_SEL_W 2
`endif

// *** hw/dacp_aux_spi.v ***
`timescale 1ns/1ps
`default_nettype none
`include "dacp_map.vh"
module dacp_aux_spi
(
  input  wire                        clock,
  input  wire                        rst_n,
  input  wire                        start,
  input  wire [`DACP_AUX_SEL_W-1:0]  sel,
  input  wire [`DACP_SPI_W-1:0]      wr_word,
  input  wire                        miso_pin,
  output wire                        busy,
  output reg                         done,
  output reg  [`DACP_SPI_W-1:0]      rd_word,
  output reg                         sclk,
  output reg                         mosi,
  output reg  [`DACP_AUX_SEL_W:0]    cs_n
);
  // Bits in one frame, sized to the bit counter.
  localparam [`DACP_SPI_CNT_W-1:0] FRAME_BITS = `DACP_SPI_W;

  reg  [3:0]                  div;
  reg  [`DACP_SPI_CNT_W-1:0]  bits;
  reg  [`DACP_SPI_W-1:0]      shift;
  reg                         active;
  reg                         miso_s1;
  reg                         miso_s2;

  assign busy = active;

  // Two flip-flops bring the returning data line into the clock domain.
  always @(posedge clock)
  begin
    miso_s1 <= miso_pin;
    miso_s2 <= miso_s1;
  end

  // Shifts one word MSB first; data change on fall, sampled on rise.
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      active  <= 1'b0;
      div     <= 4'h0;
      bits    <= {`DACP_SPI_CNT_W{1'b0}};
      shift   <= {`DACP_SPI_W{1'b0}};
      rd_word <= {`DACP_SPI_W{1'b0}};
      done    <= 1'b0;
      sclk    <= 1'b1;
      mosi    <= 1'b0;
      cs_n    <= {(`DACP_AUX_SEL_W+1){1'b1}};
    end
    else
    begin
      done <= 1'b0;
      if (!active)
      begin
        if (start)
        begin
          active <= 1'b1;
          div    <= 4'h0;
          bits   <= FRAME_BITS;
          shift  <= wr_word;
          cs_n   <= ~(({{`DACP_AUX_SEL_W{1'b0}}, 1'b1}) << sel);
        end
      end
      else if (div != `DACP_SPI_DIV)
        div <= div + 4'h1;
      else
      begin
        div <= 4'h0;
        if (sclk)
        begin
          if (bits == {`DACP_SPI_CNT_W{1'b0}})
          begin
            active  <= 1'b0;
            done    <= 1'b1;
            cs_n    <= {(`DACP_AUX_SEL_W+1){1'b1}};
            rd_word <= shift;
          end
          else
          begin
            sclk <= 1'b0;
            mosi <= shift[`DACP_SPI_W-1];
          end
        end
        else
        begin
          sclk  <= 1'b1;
          shift <= {shift[`DACP_SPI_W-2:0], miso_s2};
          bits  <= bits - {{(`DACP_SPI_CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // dacp_aux_spi
`default_nettype wire

// *** hw/dacp_sample_port.v ***
`timescale 1ns/1ps
`default_nettype none
`include "dacp_map.vh"
module dacp_sample_port
#(
  parameter IN_BUS_W    = `DACP_IN_BUS_W,
  parameter IN_SAMPLE_W = `DACP_IN_SAMPLE_W,
  parameter OUT_W       = `DACP_OUT_W
)
(
  // Clock and reset.
  input  wire                          clock,
  input  wire                          rst_n,
  // Input converter pins.
  input  wire [`DACP_IN_BUS_W-1:0]     conv_in_sample_bus_a,
  input  wire [`DACP_IN_BUS_W-1:0]     conv_in_sample_bus_b,
  input  wire                          conv_in_returned_clk_a,
  input  wire                          conv_in_returned_clk_b,
  output wire                          conv_in_clk_out_pos,
  output wire                          conv_in_clk_out_neg,
  // Input words to the core.
  output reg  [`DACP_IN_SAMPLE_W-1:0]  in_sample_a,
  output reg  [`DACP_IN_SAMPLE_W-1:0]  in_sample_b,
  output reg                           in_valid,
  // Output words from the core.
  input  wire [`DACP_OUT_W-1:0]        out_sample_a,
  input  wire [`DACP_OUT_W-1:0]        out_sample_b,
  input  wire                          out_valid,
  // Output converter pins.
  output wire                          conv_out_clk_pos,
  output wire                          conv_out_clk_neg,
  output reg  [`DACP_OUT_W-1:0]        conv_out_sample_bus_a,
  output reg  [`DACP_OUT_W-1:0]        conv_out_sample_bus_b,
  // Auxiliary serial engine.
  input  wire                          aux_start,
  input  wire [`DACP_AUX_SEL_W-1:0]    aux_sel,
  input  wire [`DACP_SPI_W-1:0]        aux_wr_word,
  output wire                          aux_busy,
  output wire                          aux_done,
  output wire [`DACP_SPI_W-1:0]        aux_rd_word,
  output wire                          aux_sclk,
  output wire                          aux_mosi,
  input  wire                          aux_miso,
  output wire [`DACP_AUX_SEL_W:0]      aux_cs_n
);
  // How this block moves samples.
  //
  // Clocks. The core clock is forwarded as a complementary pair to the
  // input converters and, as a second pair, to the output converters, so
  // both converter pairs run at our sample rate and in step with us.
  //
  // Input path. A word crosses two registers: the first takes the whole
  // bus of each channel on every rising edge, the second keeps the twelve
  // sample bits. A word that a converter launches after one of our rising
  // edges reaches the core two edges later, and a new pair arrives every
  // cycle; there is no stall and no buffer.
  //
  // Input coding. The words stay offset binary: all zeros is the lowest
  // level and mid-scale sits at the top bit alone. Nothing is converted
  // here, so the core sees exactly what the converters sent.
  //
  // Output path. A pair crosses one register, and only on a cycle in
  // which the core offers a new pair; otherwise the converters keep
  // seeing the last pair. The core therefore sets the output rate.
  //
  // Reset. The input words read mid-scale and the valid flag is low; the
  // output words rest at mid-scale, so the converters sit at their centre
  // level rather than at a rail while the core starts up.
  //
  // Serial port. The engine for the auxiliary converters lives in its own
  // module and shares nothing with the sample paths.
  //
  // Hazard. The returned converter clocks are not used for capture. They
  // mark the centre of each word for a receiver that reclocks on them,
  // but here the buses are launched from our own forwarded clock and are
  // settled at our next rising edge, so resampling on them would only add
  // a clock crossing without gaining any margin. A board with a long
  // flight time on the buses would need a different capture scheme.
  //
  // Limit. The valid flag only says the path is out of reset; it does
  // not flag a missing or stopped converter.

  // Field positions and idle levels of the sample words.
  localparam [IN_SAMPLE_W-1:0] IN_MID  = `DACP_IN_MID;
  localparam [OUT_W-1:0]       OUT_MID = `DACP_OUT_MID;
  localparam                   IN_MSB  = `DACP_IN_MSB;
  localparam                   IN_LSB  = `DACP_IN_LSB;

  // Registered input buses and the values the registers take next.
  reg  [IN_BUS_W-1:0]     in_s1_a;
  reg  [IN_BUS_W-1:0]     in_s1_b;
  reg  [IN_SAMPLE_W-1:0]  next_in_sample_a;
  reg  [IN_SAMPLE_W-1:0]  next_in_sample_b;
  reg                     next_in_valid;

  // Output words the registers take next.
  reg  [OUT_W-1:0]        next_out_a;
  reg  [OUT_W-1:0]        next_out_b;

  // Keeps the sample field of one input bus; the two lowest bits carry
  // nothing and are dropped here, so noise on them never reaches the core.
  function [IN_SAMPLE_W-1:0] take_sample;
    input [IN_BUS_W-1:0] bus;
    begin
      take_sample = bus[IN_MSB:IN_LSB];
    end
  endfunction

  // Gives the fresh output word on a load and the held word otherwise.
  function [OUT_W-1:0] pick_word;
    input             load;
    input [OUT_W-1:0] fresh;
    input [OUT_W-1:0] held;
    begin
      if (load)
        pick_word = fresh;
      else
        pick_word = held;
    end
  endfunction

  // Both converter clocks are the core clock forwarded as a pair. The
  // inverted leg comes from the same net, so the pair stays complementary.
  assign conv_in_clk_out_pos = clock;
  assign conv_in_clk_out_neg = ~clock;
  assign conv_out_clk_pos    = clock;
  assign conv_out_clk_neg    = ~clock;

  // First input stage of channel a: the whole bus on every rising edge.
  // It has no reset; it refills on the first edge and is masked by the
  // second stage until then.
  always @(posedge clock)
  begin
    in_s1_a <= conv_in_sample_bus_a;
  end

  // First input stage of channel b, taken on the same edge as channel a.
  always @(posedge clock)
  begin
    in_s1_b <= conv_in_sample_bus_b;
  end

  // Second stage value of channel a: mid-scale in reset, else its field.
  always @*
  begin
    next_in_sample_a = IN_MID;
    if (rst_n)
      next_in_sample_a = take_sample(in_s1_a);
  end

  // Second stage value of channel b, built the same way.
  always @*
  begin
    next_in_sample_b = IN_MID;
    if (rst_n)
      next_in_sample_b = take_sample(in_s1_b);
  end

  // The valid flag rises with the first word taken after reset.
  always @*
  begin
    next_in_valid = rst_n;
  end

  // Second stage: the words the core reads, a fresh pair every cycle.
  always @(posedge clock)
  begin
    in_sample_a <= next_in_sample_a;
    in_sample_b <= next_in_sample_b;
    in_valid    <= next_in_valid;
  end

  // Output value of channel a: mid-scale in reset, else loaded or held.
  always @*
  begin
    next_out_a = OUT_MID;
    if (rst_n)
      next_out_a = pick_word(out_valid, out_sample_a, conv_out_sample_bus_a);
  end

  // Output value of channel b, under the same load strobe as channel a.
  always @*
  begin
    next_out_b = OUT_MID;
    if (rst_n)
      next_out_b = pick_word(out_valid, out_sample_b, conv_out_sample_bus_b);
  end

  // Both output words change on the same edge, so the converters never
  // latch half of an old pair with half of a new one.
  always @(posedge clock)
  begin
    conv_out_sample_bus_a <= next_out_a;
    conv_out_sample_bus_b <= next_out_b;
  end

  // Serial port to the auxiliary converters. One request sends a
  // sixteen-bit word MSB first to the converter picked by the select
  // and brings back the word the converter shifts out at the same time.
  // A request made while a frame runs is dropped without notice, so the
  // core must wait for the done pulse before it asks again. The select
  // lines idle high and at most one is low during a frame; a select of 3 drives none low.
  dacp_aux_spi u_spi
  (
    .clock    (clock),
    .rst_n    (rst_n),
    .start    (aux_start),
    .sel      (aux_sel),
    .wr_word  (aux_wr_word),
    .miso_pin (aux_miso),
    .busy     (aux_busy),
    .done     (aux_done),
    .rd_word  (aux_rd_word),
    .sclk     (aux_sclk),
    .mosi     (aux_mosi),
    .cs_n     (aux_cs_n)
  );
endmodule // dacp_sample_port
`default_nettype wire

// *** bench/dacp_sample_port_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module dacp_monitor
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        in_valid,
  input wire logic        out_valid,
  input wire logic        aux_start,
  input wire logic        aux_busy,
  input wire logic        aux_done,
  input wire logic        aux_sclk,
  input wire logic        conv_in_clk_out_pos,
  input wire logic        conv_in_clk_out_neg,
  input wire logic [13:0] conv_in_sample_bus_a,
  input wire logic [11:0] in_sample_a,
  input wire logic [15:0] out_sample_a,
  input wire logic [15:0] conv_out_sample_bus_a,
  input wire logic [2:0]  aux_cs_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // An accepted serial request starts one frame.
  sequence s_go; aux_start && !aux_busy; endsequence
  property p_ck; conv_in_clk_out_pos ^ conv_in_clk_out_neg; endproperty
  property p_cap; in_valid |->
    in_sample_a == $past(conv_in_sample_bus_a[13:2], 2); endproperty
  property p_load; out_valid |=>
    conv_out_sample_bus_a == $past(out_sample_a); endproperty
  property p_hold; !out_valid |=> $stable(conv_out_sample_bus_a); endproperty
  property p_go; s_go |=> aux_busy && aux_cs_n != 3'h7; endproperty
  property p_done; s_go |-> ##[120:140] aux_done; endproperty
  property p_idle; !aux_busy |-> aux_sclk && aux_cs_n == 3'h7; endproperty
  property p_pulse; aux_done |=> !aux_done; endproperty
  a_ck: assert property (p_ck) else $error("clock pair");
  a_cap: assert property (p_cap) else $error("capture");
  a_load: assert property (p_load) else $error("load");
  a_hold: assert property (p_hold) else $error("hold");
  a_go: assert property (p_go) else $error("select");
  a_done: assert property (p_done) else $error("frame");
  a_idle: assert property (p_idle) else $error("idle");
  a_pulse: assert property (p_pulse) else $error("done");
endmodule // dacp_monitor
bind dacp_sample_port dacp_monitor mon_u (.*);
`default_nettype wire

// *** bench/dacp_conv_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dacp_conv_model
(
  input  wire logic        ck,
  input  wire logic [11:0] sa,
  output var  logic [13:0] bus_a,
  output var  logic [13:0] bus_b,
  input  wire logic        dck,
  input  wire logic [15:0] da,
  output var  logic [15:0] qa,
  input  wire logic        sck,
  input  wire logic        mosi,
  output var  logic [15:0] mo,
  output var  logic        miso
);
  // The auxiliary converter takes command bits on the clock's rise.
  always @(posedge sck) mo <= {mo[14:0], mosi};
  logic [1:0] j = 2'h0;
  // Words move on the fall so they are settled at the rise.
  always @(negedge ck)
  begin
    j <= j + 2'h1;
    bus_a <= {sa, j};
    bus_b <= {~sa, ~j};
  end
  // The output converter latches on its clock's rise.
  always @(posedge dck) qa <= da;
  // The auxiliary converter answers with alternating bits.
  initial miso = 1'b0;
  always @(negedge sck) miso <= ~miso;
endmodule // dacp_conv_model
`default_nettype wire

// *** bench/dacp_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock = 1'b0, rst_n = 1'b0, out_valid = 1'b0, aux_start = 1'b0;
  logic conv_in_returned_clk_a = 1'b0, conv_in_returned_clk_b, aux_miso;
  logic conv_in_clk_out_pos, conv_in_clk_out_neg, conv_out_clk_pos;
  logic conv_out_clk_neg, in_valid, aux_busy, aux_done, aux_sclk, aux_mosi;
  logic [13:0] conv_in_sample_bus_a, conv_in_sample_bus_b;
  logic [11:0] in_sample_a, in_sample_b, sa = 12'h0;
  logic [15:0] out_sample_a = 16'h0, out_sample_b = 16'h0, qa, aux_rd_word;
  logic [15:0] conv_out_sample_bus_a, conv_out_sample_bus_b;
  logic [15:0] aux_wr_word = 16'h5a3c, wv [3] = '{16'h0, 16'hffff, 16'h8000};
  logic [15:0] mo;
  logic [1:0] aux_sel = 2'h0;
  logic [2:0] aux_cs_n;
  int error_cnt = 0, checked = 0;
  initial forever #5 clock = ~clock;
  always #40 conv_in_returned_clk_a = ~conv_in_returned_clk_a;
  assign conv_in_returned_clk_b = conv_in_returned_clk_a;
  dacp_conv_model conv_u (.ck(conv_in_clk_out_pos), .sa(sa),
    .bus_a(conv_in_sample_bus_a), .bus_b(conv_in_sample_bus_b),
    .dck(conv_out_clk_pos), .da(conv_out_sample_bus_a), .qa(qa),
    .sck(aux_sclk), .mosi(aux_mosi), .mo(mo), .miso(aux_miso));
  dacp_sample_port dut_u (.*);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (error_cnt == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Boundary samples with toggling spare bits reach the core.
  task automatic t_in;
    foreach (wv[i])
    begin
      @(posedge clock);
      sa <= wv[i][15:4];
      repeat (4) @(posedge clock);
      #1;
      chk({4'h0, in_sample_a}, {4'h0, wv[i][15:4]});
      chk({4'h0, in_sample_b}, {4'h0, ~wv[i][15:4]});
      chk({15'h0, in_valid}, 16'h0001);
      chk({14'h0, conv_in_clk_out_pos, conv_in_clk_out_neg}, 16'h0002);
    end
  endtask
  // Paired output words load together, then hold.
  task automatic t_out;
    foreach (wv[i])
    begin
      @(posedge clock);
      out_valid <= 1'b1;
      out_sample_a <= wv[i];
      out_sample_b <= ~wv[i];
      @(posedge clock);
      #1;
      chk(conv_out_sample_bus_a, wv[i]);
      chk(conv_out_sample_bus_b, ~wv[i]);
      chk({14'h0, conv_out_clk_pos, conv_out_clk_neg}, 16'h0002);
    end
    @(posedge clock);
    out_valid <= 1'b0;
    out_sample_a <= 16'h1357;
    repeat (3) @(posedge clock);
    #1;
    chk(conv_out_sample_bus_a, 16'h8000);
    chk(qa, 16'h8000);
  endtask
  // One frame to each auxiliary converter, with a start while busy.
  task automatic t_spi;
    for (int s = 0; s < 3; s++)
    begin
      @(posedge clock);
      aux_sel <= s[1:0];
      aux_start <= 1'b1;
      repeat (2) @(posedge clock);
      aux_start <= 1'b0;
      #1;
      chk({13'h0, aux_cs_n}, {13'h0, 3'h7 ^ (3'h1 << s)});
      chk({15'h0, aux_busy}, 16'h0001);
      for (int n = 0; n < 200 && aux_done !== 1'b1; n++)
      begin
        @(posedge clock);
        #1;
      end
      chk({15'h0, aux_done}, 16'h0001);
      chk(aux_rd_word, 16'haaaa);
      chk(mo, 16'h5a3c);
    end
  endtask
  initial
  begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    t_in;
    t_out;
    t_spi;
    summarize;
  end
  initial
  begin
    #20000;
    error_cnt++;
    summarize;
  end
endmodule // testbench
`default_nettype wire
